// ### dtmc_consts.vh
`ifndef DTMC_CONSTS_VH
`define DTMC_CONSTS_VH
// ==========================================================
// register map
`define DTMC_SFR_ADDR_MODE 8'h89
`define DTMC_SFR_ADDR_LOW0 8'h8a
`define DTMC_SFR_ADDR_LOW1 8'h8b
`define DTMC_SFR_ADDR_HIGH0 8'h8c
`define DTMC_SFR_ADDR_HIGH1 8'h8d
`define DTMC_MODE_RESET 8'h00
// ==========================================================
// mode register fields
`define DTMC_TMR1_GATE_BIT 7
`define DTMC_TMR1_CT_BIT 6
`define DTMC_TMR1_MODE_HI 5
`define DTMC_TMR1_MODE_LO 4
`define DTMC_TMR0_GATE_BIT 3
`define DTMC_TMR0_CT_BIT 2
`define DTMC_TMR0_MODE_HI 1
`define DTMC_TMR0_MODE_LO 0
// ==========================================================
// mode encodings
`define DTMC_MODE_13BIT 2'h0
`define DTMC_MODE_16BIT 2'h1
`define DTMC_MODE_RELOAD 2'h2
`define DTMC_MODE_SPLIT 2'h3
// ==========================================================
// timing
`define DTMC_CLKS_PER_MCYCLE 4'hc
`define DTMC_PRESCALE_MASK 8'h1f
`endif

// ### dtmc_unit.v
`timescale 1ns/1ps
`include "dtmc_consts.vh"
// ==========================================================
// one timer/counter: low and high byte with the four modes
module dtmc_unit (
   // clock and reset
   input wire mclk,
   input wire rstn,
   // control
   input wire [1:0] mode,
   input wire low_inc,
   input wire high_inc_split,
   // software writes
   input wire wr_low,
   input wire wr_high,
   input wire [7:0] wr_data,
   // state
   output reg [7:0] low_byte_ff,
   output reg [7:0] high_byte_ff,
   output reg low_ovf_ff,
   output reg high_ovf_ff
);
   reg [7:0] nxt_low;
   reg [7:0] nxt_high;
   reg nxt_low_ovf;
   reg nxt_high_ovf;

   always @* begin
      nxt_low = low_byte_ff;
      nxt_high = high_byte_ff;
      nxt_low_ovf = 1'b0;
      nxt_high_ovf = 1'b0;
      case (mode)
         `DTMC_MODE_13BIT: begin
            if (low_inc) begin
               // upper three low bits are left free-running, readers ignore them
               nxt_low = low_byte_ff + 8'h01;
               if ((low_byte_ff & `DTMC_PRESCALE_MASK) == `DTMC_PRESCALE_MASK) begin
                  nxt_high = high_byte_ff + 8'h01;
                  nxt_low_ovf = (high_byte_ff == 8'hff);
               end
            end
         end
         `DTMC_MODE_16BIT: begin
            if (low_inc) begin
               nxt_low = low_byte_ff + 8'h01;
               if (low_byte_ff == 8'hff) begin
                  nxt_high = high_byte_ff + 8'h01;
                  nxt_low_ovf = (high_byte_ff == 8'hff);
               end
            end
         end
         `DTMC_MODE_RELOAD: begin
            if (low_inc) begin
               if (low_byte_ff == 8'hff) begin
                  nxt_low = high_byte_ff;
                  nxt_low_ovf = 1'b1;
               end else begin
                  nxt_low = low_byte_ff + 8'h01;
               end
            end
         end
         `DTMC_MODE_SPLIT: begin
            if (low_inc) begin
               nxt_low = low_byte_ff + 8'h01;
               nxt_low_ovf = (low_byte_ff == 8'hff);
            end
            if (high_inc_split) begin
               nxt_high = high_byte_ff + 8'h01;
               nxt_high_ovf = (high_byte_ff == 8'hff);
            end
         end
         default: begin
            nxt_low = low_byte_ff;
         end
      endcase
      // software write wins over a count in the same cycle
      if (wr_low) begin
         nxt_low = wr_data;
      end
      if (wr_high) begin
         nxt_high = wr_data;
      end
   end

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         low_byte_ff <= 8'h00;
         high_byte_ff <= 8'h00;
         low_ovf_ff <= 1'b0;
         high_ovf_ff <= 1'b0;
      end else begin
         low_byte_ff <= nxt_low;
         high_byte_ff <= nxt_high;
         low_ovf_ff <= nxt_low_ovf;
         high_ovf_ff <= nxt_high_ovf;
      end
   end
endmodule // dtmc_unit

// ### dtmc_top.v
// Overview of operation
// - timer 1 gate set means timer 1 counts only while its irq pin is high and run is set.
// - timer 1 source bit set counts falling edges of its count pin, else machine cycles.
// - timer 1 mode lives in bits 5:4 and timer 0 mode in bits 1:0.
// - timer 1 mode 0 is an 8-bit high byte fed by a 5-bit low prescaler.
// - timer 1 mode 1 cascades both bytes into one 16-bit counter.
// - timer 1 mode 2 counts the low byte and reloads it from the high byte on overflow.
// - timer 0 gate set means timer 0 counts only while its irq pin is high and run is set.
// - timer 0 source bit set counts falling edges of its count pin, else machine cycles.
// - timer 0 mode 0 is an 8-bit high byte fed by a 5-bit low prescaler.
// - timer 0 mode 1 cascades both bytes into one 16-bit counter.
// - timer 0 mode 2 counts the low byte and reloads it from the high byte on overflow.
// - timer 0 mode 3 makes its low byte an 8-bit counter under timer 0 controls.
// - timer 0 mode 3 makes its high byte a machine-cycle timer run by timer 1 run bit.
// - timer 1 mode 3 holds timer 1 as if its run bit were clear.
// - in 13-bit mode the count is the high byte plus low bits 4:0, upper low bits ignored.
// - timers tick every 12 clocks; pins are sampled once per machine cycle, high then low.
`timescale 1ns/1ps
`include "dtmc_consts.vh"
module dtmc_top (
   // clock and reset
   input wire mclk,
   input wire rstn,
   // special function register port
   input wire [7:0] sfr_addr,
   input wire sfr_wr,
   input wire [7:0] sfr_wdata,
   input wire sfr_rd,
   output reg [7:0] sfr_rdata_ff,
   // run bits from the control register
   input wire timer0_run_bit,
   input wire timer1_run_bit,
   // pins
   input wire ext_irq0_pin,
   input wire ext_irq1_pin,
   input wire timer0_count_pin,
   input wire timer1_count_pin,
   // overflow events to the control register
   output reg timer0_overflow_ff,
   output reg timer1_overflow_flag_ff,
   // mode register view
   output reg [7:0] timer_mode_config_ff
);
   localparam [3:0] PHASE_LAST = `DTMC_CLKS_PER_MCYCLE - 4'h1;

   reg [7:0] nxt_mode;
   reg [3:0] phase_ff;
   reg mcycle_ff;
   reg [3:0] pin_meta_ff;
   reg [3:0] pin_sync_ff;
   reg [1:0] cnt_sample_ff;
   reg [1:0] nxt_cnt_sample;
   reg [1:0] edge_ff;
   reg [7:0] nxt_rdata;

   wire tmr0_gate;
   wire tmr1_gate;
   wire tmr0_ct;
   wire tmr1_ct;
   wire [1:0] tmr0_mode;
   wire [1:0] tmr1_mode;
   wire tmr0_enable;
   wire tmr1_enable;
   wire tmr0_tick;
   wire tmr1_tick;
   wire tmr0_inc;
   wire tmr1_inc;
   wire tmr0_high_split_inc;
   wire [7:0] tmr0_low;
   wire [7:0] tmr0_high;
   wire [7:0] tmr1_low;
   wire [7:0] tmr1_high;
   wire tmr0_low_ovf;
   wire tmr0_high_ovf;
   wire tmr1_low_ovf;
   wire tmr1_high_ovf_unused;

   // ==========================================================
   // mode register
   always @* begin
      nxt_mode = timer_mode_config_ff;
      if (sfr_wr && (sfr_addr == `DTMC_SFR_ADDR_MODE)) begin
         nxt_mode = sfr_wdata;
      end
   end

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         timer_mode_config_ff <= `DTMC_MODE_RESET;
      end else begin
         timer_mode_config_ff <= nxt_mode;
      end
   end

   assign tmr1_gate = timer_mode_config_ff[`DTMC_TMR1_GATE_BIT];
   assign tmr1_ct = timer_mode_config_ff[`DTMC_TMR1_CT_BIT];
   assign tmr1_mode = timer_mode_config_ff[`DTMC_TMR1_MODE_HI:`DTMC_TMR1_MODE_LO];
   assign tmr0_gate = timer_mode_config_ff[`DTMC_TMR0_GATE_BIT];
   assign tmr0_ct = timer_mode_config_ff[`DTMC_TMR0_CT_BIT];
   assign tmr0_mode = timer_mode_config_ff[`DTMC_TMR0_MODE_HI:`DTMC_TMR0_MODE_LO];

   // ==========================================================
   // machine cycle strobe
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         phase_ff <= 4'h0;
         mcycle_ff <= 1'b0;
      end else begin
         phase_ff <= (phase_ff == PHASE_LAST) ? 4'h0 : phase_ff + 4'h1;
         mcycle_ff <= (phase_ff == PHASE_LAST);
      end
   end

   // ==========================================================
   // pin synchronisers: irq0, irq1, count0, count1
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pin_meta_ff <= 4'h0;
         pin_sync_ff <= 4'h0;
      end else begin
         pin_meta_ff <= {timer1_count_pin, timer0_count_pin, ext_irq1_pin, ext_irq0_pin};
         pin_sync_ff <= pin_meta_ff;
      end
   end

   // ==========================================================
   // counter input: sample once per machine cycle, count high then low
   always @* begin
      nxt_cnt_sample = cnt_sample_ff;
      if (mcycle_ff) begin
         nxt_cnt_sample = pin_sync_ff[3:2];
      end
   end

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cnt_sample_ff <= 2'h0;
         edge_ff <= 2'h0;
      end else begin
         cnt_sample_ff <= nxt_cnt_sample;
         // a low sample after a high one counts; needs each level one machine cycle
         edge_ff <= {2{mcycle_ff}} & cnt_sample_ff & ~pin_sync_ff[3:2];
      end
   end

   // ==========================================================
   // enables and ticks
   assign tmr0_enable = timer0_run_bit & (~tmr0_gate | pin_sync_ff[0]);
   assign tmr1_enable = timer1_run_bit & (~tmr1_gate | pin_sync_ff[1]) &
      (tmr1_mode != `DTMC_MODE_SPLIT);
   assign tmr0_tick = tmr0_ct ? edge_ff[0] : mcycle_ff;
   assign tmr1_tick = tmr1_ct ? edge_ff[1] : mcycle_ff;
   assign tmr0_inc = tmr0_enable & tmr0_tick;
   assign tmr1_inc = tmr1_enable & tmr1_tick;
   // split high byte is a pure machine-cycle timer on the timer 1 run bit
   assign tmr0_high_split_inc = timer1_run_bit & mcycle_ff;

   // ==========================================================
   // timer datapaths
   // handled per mode inside the unit
   dtmc_unit u_timer0 (
      .mclk(mclk),
      .rstn(rstn),
      .mode(tmr0_mode),
      .low_inc(tmr0_inc),
      .high_inc_split(tmr0_high_split_inc),
      .wr_low(sfr_wr && (sfr_addr == `DTMC_SFR_ADDR_LOW0)),
      .wr_high(sfr_wr && (sfr_addr == `DTMC_SFR_ADDR_HIGH0)),
      .wr_data(sfr_wdata),
      .low_byte_ff(tmr0_low),
      .high_byte_ff(tmr0_high),
      .low_ovf_ff(tmr0_low_ovf),
      .high_ovf_ff(tmr0_high_ovf)
   );

   dtmc_unit u_timer1 (
      .mclk(mclk),
      .rstn(rstn),
      .mode(tmr1_mode),
      .low_inc(tmr1_inc),
      .high_inc_split(1'b0),
      .wr_low(sfr_wr && (sfr_addr == `DTMC_SFR_ADDR_LOW1)),
      .wr_high(sfr_wr && (sfr_addr == `DTMC_SFR_ADDR_HIGH1)),
      .wr_data(sfr_wdata),
      .low_byte_ff(tmr1_low),
      .high_byte_ff(tmr1_high),
      .low_ovf_ff(tmr1_low_ovf),
      .high_ovf_ff(tmr1_high_ovf_unused)
   );

   // ==========================================================
   // overflow events, one cycle each
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         timer0_overflow_ff <= 1'b0;
         timer1_overflow_flag_ff <= 1'b0;
      end else begin
         timer0_overflow_ff <= tmr0_low_ovf;
         // timer 1 gives up its own overflow report while timer 0 is split
         timer1_overflow_flag_ff <= (tmr0_mode == `DTMC_MODE_SPLIT) ?
            tmr0_high_ovf : tmr1_low_ovf;
      end
   end

   // ==========================================================
   // read data
   always @* begin
      nxt_rdata = sfr_rdata_ff;
      if (sfr_rd) begin
         case (sfr_addr)
            `DTMC_SFR_ADDR_MODE: nxt_rdata = timer_mode_config_ff;
            `DTMC_SFR_ADDR_LOW0: nxt_rdata = tmr0_low;
            `DTMC_SFR_ADDR_LOW1: nxt_rdata = tmr1_low;
            `DTMC_SFR_ADDR_HIGH0: nxt_rdata = tmr0_high;
            `DTMC_SFR_ADDR_HIGH1: nxt_rdata = tmr1_high;
            default: nxt_rdata = 8'h00;
         endcase
      end
   end

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sfr_rdata_ff <= 8'h00;
      end else begin
         sfr_rdata_ff <= nxt_rdata;
      end
   end
endmodule // dtmc_top

// ### dtmc_top_sva.sv
`timescale 1ns/1ps
// ==========
// port checker
module dtmc_top_sva (
   // clock and reset
   input wire mclk,
   input wire rstn,
   // register port
   input wire [7:0] sfr_addr,
   input wire sfr_wr,
   input wire [7:0] sfr_wdata,
   input wire sfr_rd,
   input wire [7:0] sfr_rdata_ff,
   // controls and pins
   input wire timer0_run_bit,
   input wire timer1_run_bit,
   input wire ext_irq0_pin,
   input wire ext_irq1_pin,
   input wire timer0_count_pin,
   input wire timer1_count_pin,
   // results
   input wire timer0_overflow_ff,
   input wire timer1_overflow_flag_ff,
   input wire [7:0] timer_mode_config_ff
);
   wire [7:0] md;
   assign md = timer_mode_config_ff;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   sequence s_mode_wr;
      sfr_wr && sfr_addr == 8'h89;
   endsequence
   // held several edges so a count already in the pipe has drained
   sequence s_tmr1_held;
      (md[5:4] == 2'h3 && md[1:0] != 2'h3)[*4];
   endsequence
   a_mode_wr_lands: assert property (s_mode_wr |=> md == $past(sfr_wdata))
      else $error("mode write lost");
   a_mode_no_wr: assert property (!(sfr_wr && sfr_addr == 8'h89) |=> $stable(md))
      else $error("mode changed without write");
   a_mode_rd_val: assert property (sfr_rd && !sfr_wr && sfr_addr == 8'h89
      |=> sfr_rdata_ff == $past(md)) else $error("mode read wrong");
   a_unmapped_rd: assert property (sfr_rd && (sfr_addr < 8'h89 || sfr_addr > 8'h8d)
      |=> sfr_rdata_ff == 8'h00) else $error("unmapped read not zero");
   a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata_ff))
      else $error("read data moved");
   a_tmr1_mode3_hold: assert property (s_tmr1_held |-> !timer1_overflow_flag_ff)
      else $error("timer 1 ran in mode 3");
   a_tmr0_run_off: assert property ((!timer0_run_bit)[*3] |-> !timer0_overflow_ff)
      else $error("timer 0 ran while stopped");
   a_tmr0_gate_off: assert property ((md[3] && !ext_irq0_pin)[*6] |-> !timer0_overflow_ff)
      else $error("timer 0 ran with gate closed");
   a_tmr1_gate_off: assert property ((md[7] && md[1:0] != 2'h3 && !ext_irq1_pin)[*6]
      |-> !timer1_overflow_flag_ff) else $error("timer 1 ran with gate closed");
   a_tmr0_ovf_gap: assert property (timer0_overflow_ff |=> (!timer0_overflow_ff)[*8])
      else $error("timer 0 overflows too close");
endmodule // dtmc_top_sva
bind dtmc_top dtmc_top_sva u_chk (.*);

// ### dual_timer_mode_config_test.sv
`timescale 1ns/1ps
module dual_timer_mode_config_test;
   // ==========
   // stimulus and dut
   reg mclk = 1'b0;
   reg rstn = 1'b0;
   reg [7:0] sfr_addr = 8'h00;
   reg sfr_wr = 1'b0;
   reg [7:0] sfr_wdata = 8'h00;
   reg sfr_rd = 1'b0;
   reg [1:0] run = 2'b00;
   reg [1:0] irq = 2'b11;
   reg [1:0] cpin = 2'b00;
   wire [7:0] rdata;
   wire [7:0] mode_q;
   wire ovf0;
   wire ovf1;
   integer error_cnt = 0;
   integer tests_run = 0;
   dtmc_top dut (.mclk(mclk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata_ff(rdata),
      .timer0_run_bit(run[0]), .timer1_run_bit(run[1]), .ext_irq0_pin(irq[0]),
      .ext_irq1_pin(irq[1]), .timer0_count_pin(cpin[0]), .timer1_count_pin(cpin[1]),
      .timer0_overflow_ff(ovf0), .timer1_overflow_flag_ff(ovf1),
      .timer_mode_config_ff(mode_q));
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   // ==========
   // bus and compare
   task chk(input string n, input [7:0] e, input [7:0] g);
      tests_run = tests_run + 1;
      if (g !== e) begin
         error_cnt = error_cnt + 1;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      @(posedge mclk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge mclk);
      sfr_wr <= 1'b0;
   endtask
   task rdc(input string n, input [7:0] a, input [7:0] e, input [7:0] m);
      @(posedge mclk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge mclk);
      sfr_rd <= 1'b0;
      @(posedge mclk);
      #1 chk(n, e, rdata & m);
   endtask
   // runs stop at the first overflow so the bytes read back are fixed
   task automatic go(input [7:0] md, input [7:0] tla, input [7:0] tl, input [7:0] th,
         input [1:0] rn, input [1:0] cp, input [1:0] ex);
      reg [1:0] seen;
      integer i;
      seen = 2'b00;
      wr(8'h89, md);
      wr(tla, tl);
      wr(tla + 8'h02, th);
      @(posedge mclk);
      run <= rn;
      cpin <= cp;
      for (i = 0; i < 80; i = i + 1) begin
         @(negedge mclk);
         seen = seen | {ovf1, ovf0};
         @(posedge mclk);
         if (seen != 2'b00) run <= 2'b00;
         if (i == 30) cpin <= 2'b00;
      end
      // a run that never overflowed must not keep counting into the next setup
      run <= 2'b00;
      chk("overflow", {6'h00, ex}, {6'h00, seen});
   endtask
   // ==========
   // scenarios
   task t_reset;
      chk("mode after reset", 8'h00, mode_q);
      rdc("mode read", 8'h89, 8'h00, 8'hff);
   endtask
   task t_regs;
      wr(8'h89, 8'ha5);
      #1 chk("mode reg", 8'ha5, mode_q);
      rdc("mode read", 8'h89, 8'ha5, 8'hff);
      wr(8'h8f, 8'h3c);
      #1 chk("mode kept", 8'ha5, mode_q);
      rdc("unmapped", 8'h8e, 8'h00, 8'hff);
   endtask
   task t_modes;
      go(8'h01, 8'h8a, 8'hff, 8'hff, 2'b01, 2'b00, 2'b01);
      rdc("high0 after wrap", 8'h8c, 8'h00, 8'hff);
      go(8'h10, 8'h8b, 8'hff, 8'hff, 2'b10, 2'b00, 2'b10);
      go(8'h00, 8'h8b, 8'h1f, 8'hff, 2'b10, 2'b00, 2'b10);
      rdc("low1 prescale bits", 8'h8b, 8'h00, 8'h1f);
      go(8'h00, 8'h8a, 8'h1f, 8'hff, 2'b01, 2'b00, 2'b01);
      go(8'h02, 8'h8a, 8'hff, 8'h80, 2'b01, 2'b00, 2'b01);
      rdc("low0 reload", 8'h8a, 8'h80, 8'hff);
      go(8'h20, 8'h8b, 8'hff, 8'h80, 2'b10, 2'b00, 2'b10);
      rdc("high1 kept", 8'h8d, 8'h80, 8'hff);
   endtask
   task t_gate;
      @(posedge mclk);
      irq <= 2'b00;
      go(8'h09, 8'h8a, 8'hff, 8'hff, 2'b01, 2'b00, 2'b00);
      rdc("low0 gated", 8'h8a, 8'hff, 8'hff);
      go(8'h90, 8'h8b, 8'hff, 8'hff, 2'b10, 2'b00, 2'b00);
      go(8'h01, 8'h8a, 8'hff, 8'hff, 2'b01, 2'b00, 2'b01);
      irq <= 2'b11;
      go(8'h09, 8'h8a, 8'hff, 8'hff, 2'b01, 2'b00, 2'b01);
      go(8'h90, 8'h8b, 8'hff, 8'hff, 2'b10, 2'b00, 2'b10);
   endtask
   task t_count;
      go(8'h05, 8'h8a, 8'hff, 8'hff, 2'b01, 2'b00, 2'b00);
      go(8'h05, 8'h8a, 8'hff, 8'hff, 2'b01, 2'b01, 2'b01);
      go(8'h50, 8'h8b, 8'hff, 8'hff, 2'b10, 2'b00, 2'b00);
      go(8'h50, 8'h8b, 8'hff, 8'hff, 2'b10, 2'b10, 2'b10);
   endtask
   task t_split;
      go(8'h31, 8'h8b, 8'hff, 8'hff, 2'b10, 2'b00, 2'b00);
      rdc("low1 held", 8'h8b, 8'hff, 8'hff);
      go(8'h33, 8'h8a, 8'h00, 8'hff, 2'b10, 2'b00, 2'b10);
      rdc("low0 idle", 8'h8a, 8'h00, 8'hff);
      go(8'h33, 8'h8a, 8'hff, 8'h00, 2'b01, 2'b00, 2'b01);
      rdc("high0 idle", 8'h8c, 8'h00, 8'hff);
   endtask
   // ==========
   // run control
   task wrap_up;
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      t_reset;
      t_regs;
      t_modes;
      t_gate;
      t_count;
      t_split;
      wrap_up;
   end
   // about twelve times the expected run length
   initial begin
      repeat (20000) @(posedge mclk);
      error_cnt = error_cnt + 1;
      wrap_up;
   end
endmodule // dual_timer_mode_config_test
